// File: bmc_control.sv
// Brown-out detector control and early-warning monitor registers
//
// How it works
// - sample-rate bit picks 1 kHz or 125 Hz
// - fuse values load rate, active, sleep fields
// - active mode field bits 3:2 read-only
// - active codes off, continuous, sampled, hold-at-wake
// - sleep field bits 1:0 writable, 3 reserved
// - only sleep field is change protected
// - threshold code read-only, loaded from fuses
// - two-bit margin selects 5, 15, 25 percent
// - trigger selects below, above, or either crossing
// - interrupt enable is control bit 0
// - flag set on trigger, only while detector on and enable set
// - status bit shows supply below warning level
// - interrupt request while flag and enable set
// - monitor follows detector mode, off or sampled, and runs only while enable set
// - sleep field used in standby, active on wake
`timescale 1ns/1ps
module bmc_control
    import bmc_pkg::*;
#(
    parameter int FAST_DIV = FAST_CYCLES,  // Cycles per fast sample
    parameter int SLOW_DIV = SLOW_CYCLES   // Cycles per slow sample
) (
    input  wire logic         clk_sys_i,     // System clock, 40 MHz
    input  wire logic         rst_i,         // Async reset, active high
    input  wire bmc_fuse_type fuse_i,        // Fuse configuration
    input  wire logic         deep_sleep_i,  // Standby or power-down
    input  wire logic         below_level_i, // Comparator: below warning
    input  wire logic         unlock_i,      // Protection unlock qualifier
    input  wire logic [3:0]   addr_i,        // Register address
    input  wire logic [7:0]   wdata_i,       // Write data
    input  wire logic         wr_i,          // Write strobe
    input  wire logic         rd_i,          // Read strobe
    output logic [7:0]        rdata_o,       // Read data, cycle after rd_i
    output bmc_analog_ctl_type analog_o,     // Analog detector controls
    output logic              irq_o          // Early-warning interrupt
);

    typedef struct packed {
        logic            fuse_pending;
        logic            sample_rate_select;
        bmc_mode_type    active_mode;
        bmc_mode_type    sleep_mode;
        logic [2:0]      threshold_code;
        bmc_margin_type  warning_margin_select;
        bmc_trigger_type warning_trigger_select;
        logic            warning_irq_enable;
        logic            warning_irq_flag;
        logic            below_warning_state;
        logic            below_sync1;
        logic            below_sync2;
        logic            state_valid;
        logic [7:0]      rdata;
    } bmc_state_type;

    bmc_state_type state_ff;
    bmc_state_type nxt_state;

    bmc_mode_type mode_now;
    logic         det_on;
    logic         det_sampled;
    logic         mon_run;
    logic         sample_tick;
    logic         sample_now;
    logic         trigger_hit;
    logic         flag_set;
    logic         flag_clr;
    logic         wr_ctrl;

    // Effective detector mode for the current power state
    function automatic bmc_mode_type pick_mode(input logic sleeping,
                                               input bmc_mode_type act,
                                               input bmc_mode_type slp);
        bmc_mode_type m;
        m = sleeping ? slp : act;
        if (sleeping && slp == MODE_HOLD_AT_WAKE) begin
            m = MODE_OFF_SETTING; // Reserved sleep code runs nothing
        end
        return m;
    endfunction : pick_mode

    // Trigger match for a change of the below-level comparator
    function automatic logic trig_match(input bmc_trigger_type sel,
                                        input logic old_below,
                                        input logic new_below);
        logic hit;
        hit = 1'b0;
        unique case (sel)
            TRIG_BELOW: hit = !old_below && new_below;
            TRIG_ABOVE: hit = old_below && !new_below;
            TRIG_CROSS: hit = old_below != new_below;
            TRIG_RSVD:  hit = 1'b0;
        endcase
        return hit;
    endfunction : trig_match

    always_comb begin
        mode_now = pick_mode(deep_sleep_i, state_ff.active_mode,
                             state_ff.sleep_mode);
        det_on      = mode_now != MODE_OFF_SETTING;
        det_sampled = mode_now == MODE_SAMPLED;
        mon_run     = det_on && state_ff.warning_irq_enable;
    end

    bmc_sample_tick #(
        .FAST_DIV (FAST_DIV),
        .SLOW_DIV (SLOW_DIV)
    ) u_tick (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .run_i     (det_sampled),
        .slow_i    (state_ff.sample_rate_select),
        .tick_o    (sample_tick)
    );

    always_comb begin
        // Sampled mode looks at the comparator only on ticks
        sample_now = det_on && (!det_sampled || sample_tick);
        wr_ctrl    = wr_i && !state_ff.fuse_pending;
        trigger_hit = state_ff.state_valid &&
                      trig_match(state_ff.warning_trigger_select,
                                 state_ff.below_warning_state,
                                 state_ff.below_sync2);
        flag_set = sample_now && mon_run && trigger_hit;
        flag_clr = wr_ctrl && addr_i == ADDR_WARN_FLAG &&
                   wdata_i[IRQ_FLAG_BIT];
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_state.below_sync1 = below_level_i;
        nxt_state.below_sync2 = state_ff.below_sync1;
        nxt_state.rdata = 8'h00;

        // Fuses caught on the first clock after reset release
        if (state_ff.fuse_pending) begin
            nxt_state.fuse_pending       = 1'b0;
            nxt_state.sample_rate_select = fuse_i.sample_rate_select;
            nxt_state.active_mode        = fuse_i.active_mode;
            nxt_state.sleep_mode         = fuse_i.sleep_mode;
            nxt_state.threshold_code     = fuse_i.threshold_code;
        end

        if (sample_now) begin
            nxt_state.below_warning_state = state_ff.below_sync2;
            nxt_state.state_valid         = 1'b1;
        end
        if (!det_on) begin
            // Edge history restarts when the detector comes back
            nxt_state.state_valid = 1'b0;
        end

        if (wr_ctrl) begin
            unique case (addr_i)
                ADDR_MODE_CTRL: begin
                    // Rate and active fields ignore writes
                    if (unlock_i) begin
                        nxt_state.sleep_mode = bmc_mode_type'(
                            wdata_i[SLEEP_MODE_LSB +: 2]);
                    end
                end
                ADDR_WARN_LEVEL: begin
                    nxt_state.warning_margin_select = bmc_margin_type'(
                        wdata_i[MARGIN_LSB +: 2]);
                end
                ADDR_WARN_IRQ: begin
                    nxt_state.warning_trigger_select = bmc_trigger_type'(
                        wdata_i[TRIGGER_LSB +: 2]);
                    nxt_state.warning_irq_enable =
                        wdata_i[IRQ_ENABLE_BIT];
                end
                default: begin
                end
            endcase
        end

        if (flag_clr) begin
            nxt_state.warning_irq_flag = 1'b0;
        end
        if (flag_set) begin
            nxt_state.warning_irq_flag = 1'b1;
        end

        if (rd_i) begin
            unique case (addr_i)
                ADDR_MODE_CTRL: begin
                    nxt_state.rdata[SAMPLE_RATE_BIT] =
                        state_ff.sample_rate_select;
                    nxt_state.rdata[ACTIVE_MODE_LSB +: 2] =
                        state_ff.active_mode;
                    nxt_state.rdata[SLEEP_MODE_LSB +: 2] =
                        state_ff.sleep_mode;
                end
                ADDR_THRESH_RB: begin
                    nxt_state.rdata[THRESH_LSB +: 3] =
                        state_ff.threshold_code;
                end
                ADDR_WARN_LEVEL: begin
                    nxt_state.rdata[MARGIN_LSB +: 2] =
                        state_ff.warning_margin_select;
                end
                ADDR_WARN_IRQ: begin
                    nxt_state.rdata[TRIGGER_LSB +: 2] =
                        state_ff.warning_trigger_select;
                    nxt_state.rdata[IRQ_ENABLE_BIT] =
                        state_ff.warning_irq_enable;
                end
                ADDR_WARN_FLAG: begin
                    nxt_state.rdata[IRQ_FLAG_BIT] =
                        state_ff.warning_irq_flag;
                end
                ADDR_WARN_STATE: begin
                    nxt_state.rdata[BELOW_STATE_BIT] =
                        state_ff.below_warning_state;
                end
                default: begin
                    nxt_state.rdata = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= '{
                fuse_pending:           1'b1,
                sample_rate_select:     1'b0,
                active_mode:            MODE_OFF_SETTING,
                sleep_mode:             MODE_OFF_SETTING,
                threshold_code:         3'h0,
                warning_margin_select:  bmc_margin_type'(MARGIN_RESET),
                warning_trigger_select: bmc_trigger_type'(TRIGGER_RESET),
                warning_irq_enable:     1'b0,
                warning_irq_flag:       1'b0,
                below_warning_state:    1'b0,
                below_sync1:            1'b0,
                below_sync2:            1'b0,
                state_valid:            1'b0,
                rdata:                  8'h00
            };
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign rdata_o = state_ff.rdata;
    assign irq_o   = state_ff.warning_irq_flag &&
                     state_ff.warning_irq_enable;

    always_comb begin
        analog_o.detector_on           = det_on;
        analog_o.detector_sampled      = det_sampled;
        analog_o.sample_strobe         = sample_tick;
        analog_o.hold_at_wake          = !deep_sleep_i &&
            state_ff.active_mode == MODE_HOLD_AT_WAKE;
        analog_o.threshold_code        = state_ff.threshold_code;
        analog_o.monitor_on            = mon_run;
        analog_o.warning_margin_select = state_ff.warning_margin_select;
    end

endmodule : bmc_control

// File: bmc_control_bench.sv
// Self-checking bench for the brown-out control block
`timescale 1ns/1ps
module bmc_control_bench
    import bmc_pkg::*;
;
    logic               clk_sys_i     = 1'b0;
    logic               rst_i         = 1'b1;
    bmc_fuse_type       fuse_i        = '0;
    logic               deep_sleep_i  = 1'b0;
    logic               below_level_i = 1'b0;
    logic               unlock_i      = 1'b0;
    logic [3:0]         addr_i        = 4'h0;
    logic [7:0]         wdata_i       = 8'h00;
    logic               wr_i          = 1'b0;
    logic               rd_i          = 1'b0;
    logic [7:0]         rdata_o;
    bmc_analog_ctl_type analog_o;
    logic               irq_o;
    logic               on;
    int                 fails    = 0;
    int                 n_checks = 0;
    bmc_fuse_type       cfg [4];

    always #12.5 clk_sys_i = ~clk_sys_i;

    // Short dividers keep sampled-mode runs brief
    bmc_control #(.FAST_DIV(4), .SLOW_DIV(8)) dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .fuse_i(fuse_i),
        .deep_sleep_i(deep_sleep_i), .below_level_i(below_level_i),
        .unlock_i(unlock_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .analog_o(analog_o), .irq_o(irq_o)
    );

    task automatic chk(input string what, input logic [7:0] exp, got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic chk1(input string what, input logic exp, got);
        chk(what, {7'h00, exp}, {7'h00, got});
    endtask : chk1
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : cyc
    task automatic wr(input logic [3:0] a, input logic [7:0] v, input logic u);
        @(posedge clk_sys_i);
        addr_i   <= a;
        wdata_i  <= v;
        unlock_i <= u;
        wr_i     <= 1'b1;
        @(posedge clk_sys_i);
        wr_i     <= 1'b0;
        unlock_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e,
                      input string w);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1 chk(w, e, rdata_o);
    endtask : rd
    task automatic do_reset(input bmc_fuse_type f);
        @(posedge clk_sys_i);
        rst_i  <= 1'b1;
        fuse_i <= f;
        cyc(10);
        rst_i <= 1'b0;
        cyc(2);
    endtask : do_reset
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    initial begin
        cyc(20000);
        fails++;
        report_and_stop();
    end

    initial begin
        cfg = '{'{1'b0, MODE_SAMPLED, MODE_CONTINUOUS, 3'h0},
                '{1'b1, MODE_CONTINUOUS, MODE_SAMPLED, 3'h2},
                '{1'b0, MODE_OFF_SETTING, MODE_OFF_SETTING, 3'h7},
                '{1'b1, MODE_HOLD_AT_WAKE, MODE_CONTINUOUS, 3'h2}};
        for (int i = 0; i < 4; i++) begin
            do_reset(cfg[i]);
            on = cfg[i].active_mode != MODE_OFF_SETTING;
            rd(ADDR_MODE_CTRL, {3'h0, cfg[i][7:3]}, "mode");
            rd(ADDR_THRESH_RB, {5'h00, cfg[i][2:0]}, "thr");
            rd(ADDR_WARN_LEVEL, 8'h00, "margin rst");
            rd(ADDR_WARN_IRQ, 8'h00, "irq ctl rst");
            rd(ADDR_WARN_FLAG, 8'h00, "flag rst");
            chk1("hold", cfg[i].active_mode == MODE_HOLD_AT_WAKE,
                 analog_o.hold_at_wake);
            cyc(1);
            deep_sleep_i <= 1'b1;
            cyc(20);
            #1 chk1("sleep on", cfg[i][4:3] != 2'h0,
                    analog_o.detector_on);
            chk1("sleep smp", cfg[i][4:3] == 2'h2,
                 analog_o.detector_sampled);
            chk1("hold slp", 1'b0, analog_o.hold_at_wake);
            cyc(1);
            deep_sleep_i <= 1'b0;
            if (i == 0) begin
                wr(4'h5, 8'hFF, 1'b1);
                rd(4'h5, 8'h00, "unmapped");
                wr(ADDR_THRESH_RB, 8'hFF, 1'b1);
                rd(ADDR_THRESH_RB, 8'h00, "thr ro");
            end
            wr(ADDR_WARN_IRQ, 8'h01, 1'b0);
            cyc(30);
            #1 chk1("mon on", on, analog_o.monitor_on);
            wr(ADDR_WARN_FLAG, 8'h01, 1'b0);
            below_level_i <= 1'b1;
            cyc(40);
            rd(ADDR_WARN_FLAG, {7'h00, on}, "flag set");
            if (on)
                rd(ADDR_WARN_STATE, 8'h01, "below");
            chk1("irq", on, irq_o);
            wr(ADDR_WARN_IRQ, 8'h00, 1'b0);
            cyc(2);
            #1 chk1("irq masked", 1'b0, irq_o);
            chk1("mon off", 1'b0, analog_o.monitor_on);
            rd(ADDR_WARN_FLAG, {7'h00, on}, "flag kept");
            wr(ADDR_WARN_IRQ, 8'h01, 1'b0);
            wr(ADDR_WARN_FLAG, 8'h00, 1'b0);
            cyc(2);
            #1 chk1("irq again", on, irq_o);
            wr(ADDR_WARN_FLAG, 8'h01, 1'b0);
            cyc(2);
            #1 chk1("irq clr", 1'b0, irq_o);
            rd(ADDR_WARN_FLAG, 8'h00, "flag clr");
            cyc(1);
            below_level_i <= 1'b0;
            wr(ADDR_WARN_IRQ, 8'h00, 1'b0);
            if (i == 1) begin
                for (int t = 0; t < 4; t++) begin
                    wr(ADDR_WARN_IRQ, {5'h00, t[1:0], 1'b1}, 1'b0);
                    rd(ADDR_WARN_IRQ, {5'h00, t[1:0], 1'b1},
                       "trig");
                    cyc(8);
                    for (int s = 1; s >= 0; s--) begin
                        wr(ADDR_WARN_FLAG, 8'h01, 1'b0);
                        below_level_i <= s[0];
                        cyc(8);
                        rd(ADDR_WARN_FLAG, {7'h00, s[0] ? (t == 0 || t == 2)
                            : (t == 1 || t == 2)}, "trig fire");
                    end
                    wr(ADDR_WARN_FLAG, 8'h01, 1'b0);
                end
                for (int m = 0; m < 4; m++) begin
                    wr(ADDR_WARN_LEVEL, 8'hFC | 8'(m), 1'b0);
                    rd(ADDR_WARN_LEVEL, 8'(m), "margin");
                    chk("margin out", 8'(m),
                        8'(analog_o.warning_margin_select));
                end
            end
            $display("config test %0d done", i);
        end
        // Active bits written as 00 against fuse 11, rate bit as 0 then 1; all ignored
        wr(ADDR_MODE_CTRL, 8'h02, 1'b0);
        rd(ADDR_MODE_CTRL, 8'h1D, "locked");
        wr(ADDR_MODE_CTRL, 8'hF2, 1'b1);
        rd(ADDR_MODE_CTRL, 8'h1E, "unlocked");
        cyc(1);
        deep_sleep_i <= 1'b1;
        cyc(20);
        #1 chk1("sleep smp", 1'b1, analog_o.detector_sampled);
        wr(ADDR_MODE_CTRL, 8'h03, 1'b1);
        cyc(2);
        #1 chk1("rsvd off", 1'b0, analog_o.detector_on);
        cyc(1);
        deep_sleep_i <= 1'b0;
        #1 chk1("wake", 1'b1, analog_o.detector_on);
        $display("protection test done");
        report_and_stop();
    end
endmodule : bmc_control_bench

// File: bmc_control_chk.sv
// Port checker for the brown-out control block
`timescale 1ns/1ps
module bmc_control_chk
    import bmc_pkg::*;
#(
    parameter int FAST_DIV = FAST_CYCLES,
    parameter int SLOW_DIV = SLOW_CYCLES
) (
    input wire logic               clk_sys_i,
    input wire logic               rst_i,
    input wire bmc_fuse_type       fuse_i,
    input wire logic               deep_sleep_i,
    input wire logic               below_level_i,
    input wire logic               unlock_i,
    input wire logic [3:0]         addr_i,
    input wire logic [7:0]         wdata_i,
    input wire logic               wr_i,
    input wire logic               rd_i,
    input wire logic [7:0]         rdata_o,
    input wire bmc_analog_ctl_type analog_o,
    input wire logic               irq_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    logic clr;
    int   gap_ff;
    logic seen_ff;
    // Flag or enable writes let the request drop two cycles later
    assign clr = wr_i && (addr_i == ADDR_WARN_FLAG || addr_i == ADDR_WARN_IRQ);
    // Counter restarts whenever sampling stops, so phase is unknown
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            gap_ff  <= 0;
            seen_ff <= 1'b0;
        end else if (!analog_o.detector_sampled) begin
            gap_ff  <= 0;
            seen_ff <= 1'b0;
        end else if (analog_o.sample_strobe) begin
            gap_ff  <= 1;
            seen_ff <= 1'b1;
        end else begin
            gap_ff <= gap_ff + 1;
        end
    end
    mode_rb_a: assert property (
        $past(rd_i) && $past(addr_i) == ADDR_MODE_CTRL |-> rdata_o[4:2] ==
        {fuse_i.sample_rate_select, fuse_i.active_mode})
        else $error("mode readback differs from fuses");
    thr_load_a: assert property (
        !$past(rst_i) |-> analog_o.threshold_code == fuse_i.threshold_code)
        else $error("threshold code differs from fuses");
    act_dec_a: assert property (
        !$past(rst_i) && !deep_sleep_i |->
        analog_o.detector_on == (fuse_i.active_mode != MODE_OFF_SETTING) &&
        analog_o.detector_sampled == (fuse_i.active_mode == MODE_SAMPLED))
        else $error("awake detector mode wrong");
    mon_off_a: assert property (
        !analog_o.detector_on |-> !analog_o.monitor_on)
        else $error("monitor on with detector off");
    strobe_gate_a: assert property (
        analog_o.sample_strobe |-> analog_o.detector_sampled ||
        $past(analog_o.detector_sampled))
        else $error("sample strobe outside sampled mode");
    rate_gap_a: assert property (
        analog_o.sample_strobe && seen_ff |->
        gap_ff == (fuse_i.sample_rate_select ? SLOW_DIV : FAST_DIV))
        else $error("sample period wrong");
    rate_max_a: assert property (
        seen_ff |->
        gap_ff <= (fuse_i.sample_rate_select ? SLOW_DIV : FAST_DIV))
        else $error("sample strobe missing");
    irq_hold_a: assert property (
        irq_o && !clr && !$past(clr) |=> irq_o)
        else $error("interrupt dropped without clear");
    irq_c: cover property ($rose(irq_o));
    slow_c: cover property (analog_o.sample_strobe && seen_ff &&
        fuse_i.sample_rate_select);
    sleep_c: cover property (deep_sleep_i && analog_o.detector_sampled);
endmodule : bmc_control_chk

bind bmc_control bmc_control_chk #(
    .FAST_DIV(FAST_DIV),
    .SLOW_DIV(SLOW_DIV)
) u_chk (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .fuse_i(fuse_i),
    .deep_sleep_i(deep_sleep_i),
    .below_level_i(below_level_i),
    .unlock_i(unlock_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .analog_o(analog_o),
    .irq_o(irq_o)
);

// File: bmc_pkg.sv
// Package: register map, field layout and timing for the brown-out control
package bmc_pkg;

    // Register offsets (byte-wide port)
    localparam logic [3:0] ADDR_MODE_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_THRESH_RB   = 4'h1;
    localparam logic [3:0] ADDR_WARN_LEVEL  = 4'h8;
    localparam logic [3:0] ADDR_WARN_IRQ    = 4'h9;
    localparam logic [3:0] ADDR_WARN_FLAG   = 4'hA;
    localparam logic [3:0] ADDR_WARN_STATE  = 4'hB;

    // Field positions
    localparam int SAMPLE_RATE_BIT   = 4;
    localparam int ACTIVE_MODE_LSB   = 2;
    localparam int SLEEP_MODE_LSB    = 0;
    localparam int THRESH_LSB        = 0;
    localparam int MARGIN_LSB        = 0;
    localparam int TRIGGER_LSB       = 1;
    localparam int IRQ_ENABLE_BIT    = 0;
    localparam int IRQ_FLAG_BIT      = 0;
    localparam int BELOW_STATE_BIT   = 0;

    // Reset values of software registers
    localparam logic [1:0] MARGIN_RESET  = 2'h0;
    localparam logic [1:0] TRIGGER_RESET = 2'h0;

    // Timing: system clock and sample rates
    localparam int CLK_HZ        = 40000000;
    localparam int SAMPLE_FAST_HZ = 1000;
    localparam int SAMPLE_SLOW_HZ = 125;
    localparam int FAST_CYCLES   = CLK_HZ / SAMPLE_FAST_HZ;
    localparam int SLOW_CYCLES   = CLK_HZ / SAMPLE_SLOW_HZ;

    // Detector operating modes
    typedef enum logic [1:0] {
        MODE_OFF_SETTING  = 2'b00,
        MODE_CONTINUOUS   = 2'b01,
        MODE_SAMPLED      = 2'b10,
        MODE_HOLD_AT_WAKE = 2'b11
    } bmc_mode_type;

    // Early-warning margin codes
    typedef enum logic [1:0] {
        MARGIN_5PCT  = 2'b00,
        MARGIN_15PCT = 2'b01,
        MARGIN_25PCT = 2'b10,
        MARGIN_RSVD  = 2'b11
    } bmc_margin_type;

    // Trigger conditions
    typedef enum logic [1:0] {
        TRIG_BELOW = 2'b00,
        TRIG_ABOVE = 2'b01,
        TRIG_CROSS = 2'b10,
        TRIG_RSVD  = 2'b11
    } bmc_trigger_type;

    // Fuse configuration bundle
    typedef struct packed {
        logic         sample_rate_select;
        bmc_mode_type active_mode;
        bmc_mode_type sleep_mode;
        logic [2:0]   threshold_code;
    } bmc_fuse_type;

    // Control outputs toward the analog detector
    typedef struct packed {
        logic           detector_on;
        logic           detector_sampled;
        logic           sample_strobe;
        logic           hold_at_wake;
        logic [2:0]     threshold_code;
        logic           monitor_on;
        bmc_margin_type warning_margin_select;
    } bmc_analog_ctl_type;

endpackage : bmc_pkg

// File: bmc_sample_tick.sv
// Sample tick divider: one-cycle strobe at the selected rate
`timescale 1ns/1ps
module bmc_sample_tick
    import bmc_pkg::*;
#(
    parameter int FAST_DIV = FAST_CYCLES,  // Cycles per 1 kHz tick
    parameter int SLOW_DIV = SLOW_CYCLES   // Cycles per 125 Hz tick
) (
    input  wire logic clk_sys_i,   // System clock
    input  wire logic rst_i,       // Async reset, active high
    input  wire logic run_i,       // Count while high
    input  wire logic slow_i,      // 1 selects the slow rate
    output logic      tick_o       // One-cycle sample strobe
);
    localparam int CW = $clog2(SLOW_DIV + 1);

    typedef struct packed {
        logic [CW-1:0] count;
        logic          tick;
    } bmc_tick_state_type;

    bmc_tick_state_type state_ff;
    bmc_tick_state_type nxt_state;
    logic [CW-1:0]      limit;

    always_comb begin
        limit = slow_i ? CW'(SLOW_DIV - 1) : CW'(FAST_DIV - 1);
        nxt_state = state_ff;
        nxt_state.tick = 1'b0;
        if (!run_i) begin
            nxt_state.count = '0;
        end else if (state_ff.count >= limit) begin
            // >= so a rate change mid-count never overruns
            nxt_state.count = '0;
            nxt_state.tick  = 1'b1;
        end else begin
            nxt_state.count = state_ff.count + CW'(1);
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign tick_o = state_ff.tick;

endmodule : bmc_sample_tick
